// File: hw/chb_trim_pkg.sv
// chb_trim_pkg: shared constants for the channel-b trim and pattern block
// assumes: included before any module of the block; no other dependencies
package chb_trim_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOOP_EN  = 8'h66;
  localparam logic [7:0] ADDR_GAIN     = 8'h68;
  localparam logic [7:0] ADDR_FINE     = 8'h6a;
  localparam logic [7:0] ADDR_PATTERN  = 8'h75;
  localparam logic [7:0] ADDR_PEDESTAL = 8'h76;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LOOP_EN_BIT  = 6;
  localparam int COARSE_MSB   = 7;
  localparam int COARSE_LSB   = 4;
  localparam int PERIOD_MSB   = 3;
  localparam int PERIOD_LSB   = 0;
  localparam int FINE_MSB     = 6;
  localparam int PATTERN_MSB  = 2;
  localparam int PED_MSB      = 5;
  localparam int PED_LSB      = 3;
  localparam int CUST_LO_MSB  = 7;
  localparam int CUST_LO_LSB  = 3;
  localparam int CUST_HI_MSB  = 5;

  // ----------------------------------------------------------------
  // reset values and legal limits
  // ----------------------------------------------------------------
  localparam logic       RST_LOOP_EN = 1'b0;
  localparam logic [3:0] RST_COARSE  = 4'h0;
  localparam logic [3:0] RST_PERIOD  = 4'h0;
  localparam logic [6:0] RST_FINE    = 7'h00;
  localparam logic [2:0] RST_PATTERN = 3'h0;
  localparam logic [2:0] RST_PED     = 3'h0;
  localparam logic [3:0] MAX_COARSE  = 4'hc;
  localparam logic [3:0] MAX_PERIOD  = 4'hb;

  // ----------------------------------------------------------------
  // data path constants
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 11;
  localparam int          LATENCY    = 22;
  localparam int          Q_SHIFT    = 10;
  localparam logic [10:0] MID_CODE   = 11'h400;
  localparam logic [10:0] FULL_SCALE = 11'h7ff;
  localparam logic [10:0] TOGGLE_A   = 11'h2aa;
  localparam logic [10:0] TOGGLE_B   = 11'h555;
  localparam logic [2:0]  RAMP_LAST  = 3'h7;
  localparam logic [11:0] FINE_UNITY = 12'h400;
  localparam int unsigned LOOP_BASE  = 262144;

  // coarse gain multipliers, 10 fractional bits, 0.5 db apart
  localparam logic [11:0] COARSE_MULT [0:12] = '{
    12'h400, 12'h43d, 12'h47d, 12'h4c1, 12'h509, 12'h556, 12'h5a6,
    12'h5fc, 12'h657, 12'h6b7, 12'h71d, 12'h789, 12'h7fb};

  // output source selection codes
  typedef enum logic [2:0] {
    pat_normal = 3'b000,
    pat_zeros  = 3'b001,
    pat_ones   = 3'b010,
    pat_toggle = 3'b011,
    pat_ramp   = 3'b100,
    pat_custom = 3'b101,
    pat_spare6 = 3'b110,
    pat_spare7 = 3'b111
  } pattern_type;

endpackage

// File: hw/chb_trim_top.sv
// chb_trim_top: channel-b configuration registers, gain, offset loop,
// test pattern generator and output formatter of a dual 11-bit converter
// assumes: clk is the sample clock, one converted word per cycle arrives
// on adc_sample, and an external ddr cell serialises the lvds bit pairs
//
// Contract
// - loop enable bit d6 switches offset loop
// - coarse field sets gain in 0.5 db steps
// - coarse gain resets to zero db code
// - period code doubles loop period from 256k
// - channel-b fields act only under independent control
// - fine trim adds 20log10(1+code/1024) db
// - total gain is coarse plus fine trim
// - pattern code picks data, zeros or ones
// - toggle pattern alternates two complementary words
// - ramp steps one lsb every eight clocks
// - custom pattern comes from custom registers
// - lvds words carry dummy lsb, zero for data
// - enabled loop converges output to midcode plus pedestal
// - pedestal field is signed lsb offset
// - both channels sample on same clock edge
// - converted sample appears 22 cycles later; the output register makes it 23 at the pins
// - output coding offset binary or two's complement
// - output on lvds ddr or cmos bus
// - even bits on rise, odd on fall
// - custom low five bits from d7..d3
// - custom high six bits from d5..d0
`timescale 1ns/1ns
`default_nettype none

module chb_trim_top
  import chb_trim_pkg::*;
#(
  parameter int unsigned LOOP_BASE_CYCLES = LOOP_BASE  // shortest loop period
) (
  input  wire logic        clk, // sample clock
  input  wire logic        rst_b, // sync reset, active low
  input  wire logic        reg_wr_en, // register write strobe
  input  wire logic [7:0]  reg_addr, // register offset
  input  wire logic [7:0]  reg_wr_data, // register write data
  output logic      [7:0]  reg_rd_data, // register read data
  input  wire logic        indep_ctrl, // per-channel control on
  input  wire logic        cha_loop_on, // shared loop enable
  input  wire logic [3:0]  cha_coarse_code, // shared coarse gain
  input  wire logic [3:0]  cha_period_code, // shared loop period
  input  wire logic [6:0]  cha_fine_code, // shared fine gain
  input  wire logic [2:0]  cha_pattern_code, // shared pattern select
  input  wire logic [2:0]  cha_offset_code, // shared pedestal
  input  wire logic [7:0]  custom_low_reg, // custom pattern low reg
  input  wire logic [7:0]  custom_high_reg, // custom pattern high reg
  input  wire logic [10:0] adc_sample, // raw converted word
  input  wire logic        twos_comp_sel, // two's complement coding
  input  wire logic        lvds_mode, // lvds bus, else cmos
  output logic      [10:0] cmos_data, // parallel cmos word
  output logic      [5:0]  lvds_rise_bits, // even bits, rising edge
  output logic      [5:0]  lvds_fall_bits, // odd bits, falling edge
  output logic             output_clock_true // ddr output clock enable
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic        chb_offset_loop_on; // loop enable bit
  logic [3:0]  chb_coarse_gain_code; // coarse gain field
  logic [3:0]  chb_loop_period_code; // loop time constant field
  logic [6:0]  chb_fine_gain_code; // fine gain field
  logic [2:0]  chb_output_pattern_code;   // pattern select field
  logic [2:0]  chb_converged_offset_code; // pedestal field

  // register writes; only defined bits are stored
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chb_offset_loop_on        <= RST_LOOP_EN;
      chb_coarse_gain_code      <= RST_COARSE;
      chb_loop_period_code      <= RST_PERIOD;
      chb_fine_gain_code        <= RST_FINE;
      chb_output_pattern_code   <= RST_PATTERN;
      chb_converged_offset_code <= RST_PED;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_LOOP_EN) begin
        chb_offset_loop_on <= reg_wr_data[LOOP_EN_BIT];
      end else if (reg_addr == ADDR_GAIN) begin
        chb_coarse_gain_code <= reg_wr_data[COARSE_MSB:COARSE_LSB];
        chb_loop_period_code <= reg_wr_data[PERIOD_MSB:PERIOD_LSB];
      end else if (reg_addr == ADDR_FINE) begin
        chb_fine_gain_code <= reg_wr_data[FINE_MSB:0];
      end else if (reg_addr == ADDR_PATTERN) begin
        chb_output_pattern_code <= reg_wr_data[PATTERN_MSB:0];
      end else if (reg_addr == ADDR_PEDESTAL) begin
        chb_converged_offset_code <= reg_wr_data[PED_MSB:PED_LSB];
      end
    end
  end

  // registered read back; reserved bits and unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rd_data <= 8'h00;
    end else if (reg_addr == ADDR_LOOP_EN) begin
      reg_rd_data <= 8'h00;
      reg_rd_data[LOOP_EN_BIT] <= chb_offset_loop_on;
    end else if (reg_addr == ADDR_GAIN) begin
      reg_rd_data <= {chb_coarse_gain_code, chb_loop_period_code};
    end else if (reg_addr == ADDR_FINE) begin
      reg_rd_data <= {1'b0, chb_fine_gain_code};
    end else if (reg_addr == ADDR_PATTERN) begin
      reg_rd_data <= {5'h00, chb_output_pattern_code};
    end else if (reg_addr == ADDR_PEDESTAL) begin
      reg_rd_data <= {2'b00, chb_converged_offset_code, 3'b000};
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // effective settings
  // ----------------------------------------------------------------
  logic        loop_eff;    // loop enable in force
  logic [3:0]  coarse_eff;  // coarse code in force, clamped
  logic [3:0]  period_eff;  // period code in force, clamped
  logic [6:0]  fine_eff;    // fine code in force
  pattern_type pattern_eff; // pattern in force
  logic [2:0]  ped_eff;     // pedestal code in force

  // own fields only under independent control, else shared ones
  always_comb begin
    if (indep_ctrl) begin
      loop_eff    = chb_offset_loop_on;
      coarse_eff  = chb_coarse_gain_code;
      period_eff  = chb_loop_period_code;
      fine_eff    = chb_fine_gain_code;
      pattern_eff = pattern_type'(chb_output_pattern_code);
      ped_eff     = chb_converged_offset_code;
    end else begin
      loop_eff    = cha_loop_on;
      coarse_eff  = cha_coarse_code;
      period_eff  = cha_period_code;
      fine_eff    = cha_fine_code;
      pattern_eff = pattern_type'(cha_pattern_code);
      ped_eff     = cha_offset_code;
    end
    // undefined codes are held at the top legal code
    if (coarse_eff > MAX_COARSE) begin
      coarse_eff = MAX_COARSE;
    end
    if (period_eff > MAX_PERIOD) begin
      period_eff = MAX_PERIOD;
    end
  end

  // ----------------------------------------------------------------
  // latency pipeline
  // ----------------------------------------------------------------
  logic [10:0] sample_pipe [0:LATENCY-1]; // delay line, last stage feeds out

  // both channels share this clock edge; words walk the delay line
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < LATENCY; i++) begin
        sample_pipe[i] <= 11'h000;
      end
    end else begin
      sample_pipe[0] <= adc_sample;
      for (int i = 1; i < LATENCY; i++) begin
        sample_pipe[i] <= sample_pipe[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // gain and offset correction
  // ----------------------------------------------------------------
  logic signed [11:0] offset_corr; // loop correction in lsb
  logic signed [12:0] centred; // sample about midcode
  logic signed [25:0] coarse_prod; // centred times coarse factor
  logic signed [15:0] coarse_q; // coarse result, integer lsb
  logic        [11:0] fine_mult; // 1 + code/1024 in q10
  logic signed [28:0] fine_prod; // coarse result times fine factor
  logic signed [17:0] fine_q; // fine result, integer lsb
  logic signed [17:0] corrected; // gained word plus correction
  logic        [10:0] gained_word; // saturated converted word

  // scale about midcode, add loop correction, clip to full scale
  always_comb begin
    centred     = $signed({2'b00, sample_pipe[LATENCY-1]})
                - $signed({2'b00, MID_CODE});
    coarse_prod = centred * $signed({1'b0, COARSE_MULT[coarse_eff]});
    coarse_q    = coarse_prod[Q_SHIFT+15:Q_SHIFT];
    fine_mult   = FINE_UNITY + {5'h00, fine_eff};
    fine_prod   = coarse_q * $signed({1'b0, fine_mult});
    fine_q      = fine_prod[Q_SHIFT+17:Q_SHIFT];
    corrected   = fine_q + 18'(offset_corr)
                + $signed({7'h00, MID_CODE});
    if (corrected < 0) begin
      gained_word = 11'h000;
    end else if (corrected > $signed({7'h00, FULL_SCALE})) begin
      gained_word = FULL_SCALE;
    end else begin
      gained_word = corrected[10:0];
    end
  end

  // ----------------------------------------------------------------
  // offset correction loop
  // ----------------------------------------------------------------
  logic signed [12:0] loop_target; // midcode plus pedestal
  logic signed [12:0] loop_err; // output minus target
  logic signed [47:0] err_acc; // error summed over one period
  logic        [31:0] period_cnt; // cycles into current period
  logic        [31:0] period_len; // cycles per period
  logic               period_end; // last cycle of a period

  // target and period from the effective settings
  always_comb begin
    loop_target = $signed({2'b00, MID_CODE})
                + 13'(signed'(ped_eff));
    loop_err    = $signed({2'b00, gained_word}) - loop_target;
    period_len  = LOOP_BASE_CYCLES << period_eff;
    period_end  = (period_cnt == period_len - 32'h1);
  end

  // period counter runs only while the loop is on
  always_ff @(posedge clk) begin
    if (!rst_b || !loop_eff || period_end) begin
      period_cnt <= 32'h0;
    end else begin
      period_cnt <= period_cnt + 32'h1;
    end
  end

  // error accumulation over the period, on converted data only
  always_ff @(posedge clk) begin
    if (!rst_b || !loop_eff || period_end) begin
      err_acc <= 48'sh0;
    end else if (pattern_eff == pat_normal) begin
      err_acc <= err_acc + 48'(loop_err);
    end
  end

  // one lsb step per period toward the target, cleared when off
  always_ff @(posedge clk) begin
    if (!rst_b || !loop_eff) begin
      offset_corr <= 12'sh0;
    end else if (period_end) begin
      if (err_acc > 0) begin
        offset_corr <= offset_corr - 12'sh1;
      end else if (err_acc < 0) begin
        offset_corr <= offset_corr + 12'sh1;
      end
    end
  end

  // ----------------------------------------------------------------
  // test pattern generator
  // ----------------------------------------------------------------
  logic        toggle_phase;  // selects second toggle word
  logic [2:0]  ramp_div;      // eight-clock prescaler
  logic [10:0] ramp_word;     // ramp value

  // toggle flips every clock
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      toggle_phase <= 1'b0;
    end else begin
      toggle_phase <= ~toggle_phase;
    end
  end

  // ramp climbs one lsb every eighth clock and wraps after full scale
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ramp_div  <= 3'h0;
      ramp_word <= 11'h000;
    end else begin
      ramp_div <= ramp_div + 3'h1;
      if (ramp_div == RAMP_LAST) begin
        ramp_word <= ramp_word + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // output source and coding
  // ----------------------------------------------------------------
  logic [10:0] next_word;   // 11-bit word for the next output
  logic        next_dummy;  // dummy lsb for the next lvds word

  // source select; the change applies to the next word out
  always_comb begin
    next_dummy = 1'b0;
    case (pattern_eff)
      pat_normal: begin
        next_word = gained_word;
        if (twos_comp_sel) begin
          next_word[DATA_W-1] = ~gained_word[DATA_W-1];
        end
      end
      pat_zeros: begin
        next_word = 11'h000;
      end
      pat_ones: begin
        next_word  = FULL_SCALE;
        next_dummy = 1'b1;
      end
      pat_toggle: begin
        next_word = toggle_phase ? TOGGLE_B : TOGGLE_A;
      end
      pat_ramp: begin
        next_word = ramp_word;
      end
      pat_custom: begin
        next_word = {custom_high_reg[CUST_HI_MSB:0],
                     custom_low_reg[CUST_LO_MSB:CUST_LO_LSB]};
      end
      default: begin
        next_word = 11'h000;  // unused codes drive zeros
      end
    endcase
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [11:0] lvds_word;  // data word with dummy lsb below it

  // twelve-bit lvds word, dummy bit sits at bit 0
  always_comb begin
    lvds_word = {next_word, next_dummy};
  end

  // drive the bus of the chosen interface, the other one held low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmos_data      <= 11'h000;
      lvds_rise_bits <= 6'h00;
      lvds_fall_bits <= 6'h00;
    end else if (lvds_mode) begin
      cmos_data <= 11'h000;
      for (int i = 0; i < 6; i++) begin
        lvds_rise_bits[i] <= lvds_word[2*i];
        lvds_fall_bits[i] <= lvds_word[2*i+1];
      end
    end else begin
      cmos_data      <= next_word;
      lvds_rise_bits <= 6'h00;
      lvds_fall_bits <= 6'h00;
    end
  end

  // ddr clock runs only in lvds mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      output_clock_true <= 1'b0;
    end else begin
      output_clock_true <= lvds_mode;
    end
  end

endmodule

`default_nettype wire

// File: tb/chb_capture_model.sv
// chb_capture_model: capture logic at the far side of the output bus
// assumes: fed straight from chb_trim_top outputs, no clock needed
`timescale 1ns/1ns
`default_nettype none

module chb_capture_model (
  input  wire logic        output_clock_true, // lvds bus in use
  input  wire logic [10:0] cmos_data,         // parallel word
  input  wire logic [5:0]  lvds_rise_bits,    // even bits
  input  wire logic [5:0]  lvds_fall_bits,    // odd bits
  output logic      [10:0] data_word,         // captured 11-bit word
  output logic             dummy_bit          // lvds dummy lsb
);
  // ----------------------------------------------------------------
  // word rebuild
  // ----------------------------------------------------------------
  logic [11:0] word12; // lvds pairs back in bit order

  // interleave rise and fall halves into one 12-bit word
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      word12[2*i]   = lvds_rise_bits[i];
      word12[2*i+1] = lvds_fall_bits[i];
    end
  end

  // the dummy lsb goes out on dummy_bit, only the upper 11 bits form data_word
  assign data_word = output_clock_true ? word12[11:1] : cmos_data;
  assign dummy_bit = word12[0];
endmodule

`default_nettype wire

// File: tb/chb_trim_properties.sv
// chb_trim_properties: port assertions for the channel-b trim block
// assumes: bound into chb_trim_top; cha_* inputs steer the checked cases
`timescale 1ns/1ns
`default_nettype none

module chb_trim_properties
  import chb_trim_pkg::*;
(
  input wire logic        clk, // sample clock
  input wire logic        rst_b, // sync reset
  input wire logic        reg_wr_en, // write strobe
  input wire logic [7:0]  reg_addr, // offset
  input wire logic [7:0]  reg_wr_data, // write data
  input wire logic [7:0]  reg_rd_data, // read data
  input wire logic        indep_ctrl, // own fields govern
  input wire logic        cha_loop_on, // shared loop enable
  input wire logic [3:0]  cha_coarse_code, // shared coarse gain
  input wire logic [6:0]  cha_fine_code, // shared fine gain
  input wire logic [2:0]  cha_pattern_code, // shared pattern
  input wire logic [7:0]  custom_low_reg, // custom low
  input wire logic [7:0]  custom_high_reg, // custom high
  input wire logic [10:0] adc_sample, // raw word
  input wire logic        twos_comp_sel, // coding select
  input wire logic        lvds_mode, // bus select
  input wire logic [10:0] cmos_data, // cmos word
  input wire logic [5:0]  lvds_rise_bits, // even bits
  input wire logic [5:0]  lvds_fall_bits, // odd bits
  input wire logic        output_clock_true // ddr clock enable
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic       shared_on; // shared settings drive a cmos bus
  logic [5:0] calm_cnt;  // cycles of plain pass-through setup
  logic [5:0] ramp_cnt;  // cycles of shared ramp selection

  assign shared_on = !indep_ctrl && !lvds_mode;

  // count cycles of unity gain, loop off and normal data
  always_ff @(posedge clk) begin
    if (!rst_b || !shared_on || cha_loop_on || twos_comp_sel
        || cha_coarse_code != 4'h0 || cha_fine_code != 7'h00
        || cha_pattern_code != 3'h0)
      calm_cnt <= 6'h00;
    else if (calm_cnt != 6'h3f)
      calm_cnt <= calm_cnt + 6'h01;
  end

  // count cycles of ramp selection
  always_ff @(posedge clk) begin
    if (!rst_b || !shared_on || cha_pattern_code != 3'b100)
      ramp_cnt <= 6'h00;
    else if (ramp_cnt != 6'h3f)
      ramp_cnt <= ramp_cnt + 6'h01;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  data_latency_a: assert property (
    calm_cnt >= 6'd25 |-> cmos_data == $past(adc_sample, 23))
    else $error("converted word late or altered");
  toggle_flip_a: assert property (
    (shared_on && cha_pattern_code == 3'b011) [*2] |=>
    cmos_data == ~$past(cmos_data)
    && (cmos_data == TOGGLE_A || cmos_data == TOGGLE_B))
    else $error("toggle word wrong");
  ones_word_a: assert property (
    $past(rst_b && shared_on && cha_pattern_code == 3'b010)
    |-> cmos_data == FULL_SCALE)
    else $error("all-ones word wrong");
  zero_word_a: assert property (
    $past(rst_b && !indep_ctrl && cha_pattern_code inside {3'b001,
    3'b110, 3'b111}) |-> cmos_data == 11'h000
    && lvds_rise_bits == 6'h00 && lvds_fall_bits == 6'h00)
    else $error("zero word wrong");
  custom_word_a: assert property (
    $past(rst_b && shared_on && cha_pattern_code == 3'b101)
    |-> cmos_data == {$past(custom_high_reg[5:0]),
    $past(custom_low_reg[7:3])})
    else $error("custom word wrong");
  ramp_step_a: assert property (
    ramp_cnt >= 6'd12 && cmos_data != $past(cmos_data)
    |-> cmos_data == $past(cmos_data) + 11'h001
    && $past(cmos_data) == $past(cmos_data, 8))
    else $error("ramp step wrong");
  mode_split_a: assert property (
    $past(rst_b) |-> output_clock_true == $past(lvds_mode)
    && (output_clock_true ? cmos_data == 11'h000
    : {lvds_rise_bits, lvds_fall_bits} == 12'h000))
    else $error("idle bus not quiet");
  data_dummy_a: assert property (
    $past(rst_b && lvds_mode && !indep_ctrl && cha_pattern_code == 3'h0)
    |-> !lvds_rise_bits[0])
    else $error("dummy bit set on data");
  pattern_read_a: assert property (
    reg_wr_en && reg_addr == ADDR_PATTERN
    ##1 !reg_wr_en && reg_addr == ADDR_PATTERN
    |=> reg_rd_data == {5'h00, $past(reg_wr_data[2:0], 2)})
    else $error("pattern readback wrong");
endmodule

bind chb_trim_top chb_trim_properties u_chb_trim_properties (.*);

`default_nettype wire

// File: tb/chb_trim_top_tb.sv
// chb_trim_top_tb: register, data path and pattern tests of chb_trim_top
// assumes: package, capture model and checker compiled before this file
`timescale 1ns/1ns
`default_nettype none

module chb_trim_top_tb;
  import chb_trim_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        indep_ctrl = 1'b0;
  logic        cha_loop_on = 1'b0;
  logic [3:0]  cha_coarse_code = 4'h0;
  logic [3:0]  cha_period_code = 4'h0;
  logic [6:0]  cha_fine_code = 7'h00;
  logic [2:0]  cha_pattern_code = 3'h0;
  logic [2:0]  cha_offset_code = 3'h0;
  logic [7:0]  custom_low_reg = 8'h5f; // junk in low three bits
  logic [7:0]  custom_high_reg = 8'hf3; // junk in top two bits
  logic [10:0] adc_sample = 11'h400;
  logic        twos_comp_sel = 1'b0;
  logic        lvds_mode = 1'b0;
  logic [7:0]  reg_rd_data;
  logic [10:0] cmos_data;
  logic [5:0]  lvds_rise_bits;
  logic [5:0]  lvds_fall_bits;
  logic        output_clock_true;
  logic [10:0] data_word; // captured word
  logic        dummy_bit; // captured dummy lsb
  int          num_errors = 0;
  int          tests_run = 0;
  logic [7:0]  reg_at [6] = '{ADDR_LOOP_EN, ADDR_GAIN, ADDR_FINE,
                             ADDR_PATTERN, ADDR_PEDESTAL, 8'h70};
  logic [7:0]  reg_keep [6] = '{8'h40, 8'hff, 8'h7f, 8'h07, 8'h38, 8'h00};

  always #50 clk = ~clk;

  chb_trim_top #(.LOOP_BASE_CYCLES(16)) u_chb_trim_top (.*);
  chb_capture_model u_chb_capture_model (.*);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
  endtask

  // read data lands one edge after the offset
  task automatic rd_check(input logic [7:0] a, input logic [7:0] want);
    reg_addr = a;
    tick(1);
    check(reg_rd_data, want);
  endtask

  task automatic set_pat(input logic [2:0] c);
    if (indep_ctrl)
      wr(ADDR_PATTERN, {5'h00, c});
    else
      cha_pattern_code = c;
  endtask

  // ramp holds each code eight cycles, then adds one
  task automatic ramp_step;
    logic [10:0] w;
    int          n;
    w = data_word;
    for (n = 0; data_word === w && n < 10; n++)
      tick(1);
    check(n < 10, 1'b1);
    w = data_word;
    repeat (2) begin
      tick(7);
      check(data_word, w);
      tick(1);
      check(data_word, w + 11'h001);
      w = data_word;
    end
  endtask

  // gain of coarse code c with fine code 127-8c, floor at each stage
  function automatic logic [10:0] gain_want(input int s, input int c);
    int v;
    v = ((s - 1024) * int'(COARSE_MULT[c > 12 ? 12 : c])) >>> 10;
    v = ((v * (1151 - 8 * c)) >>> 10) + 1024;
    if (v > 2047)
      v = 2047;
    return 11'(v);
  endfunction

  task automatic summarize;
    $display("compares %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard
  initial begin
    #10_000_000;
    num_errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] w0;
    int          n, steps, per;
    tick(4);
    rst_b = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_check(reg_at[i], 8'h00);
      wr(reg_at[i], 8'hff);
      rd_check(reg_at[i], reg_keep[i]);
      wr(reg_at[i], 8'h00);
    end
    $display("test registers done");
    adc_sample = 11'h123;
    tick(30);
    adc_sample = 11'h456;
    tick(22);
    check(data_word, 11'h123);
    tick(1);
    check(data_word, 11'h456);
    twos_comp_sel = 1'b1;
    tick(24);
    check(data_word, 11'h056);
    twos_comp_sel = 1'b0;
    $display("test latency done");
    indep_ctrl = 1'b1;
    lvds_mode = 1'b1;
    for (int k = 0; k < 32; k++) begin
      adc_sample = k[4] ? 11'h384 : 11'h464;
      wr(ADDR_GAIN, {k[3:0], 4'h0});
      wr(ADDR_FINE, {1'b0, 7'(127 - 8 * k[3:0])});
      tick(24);
      w0 = gain_want(int'(adc_sample), int'(k[3:0]));
      check(data_word, w0);
      check(dummy_bit, 1'b0);
    end
    $display("test gain done");
    wr(ADDR_FINE, 8'h00);
    adc_sample = 11'h3f8;
    for (int j = 0; j < 2; j++) begin
      per = 16 << (1 - j);
      steps = j ? 4 : 11;
      w0 = j ? 11'd1020 : 11'd1027;
      wr(ADDR_GAIN, 8'(1 - j));
      wr(ADDR_PEDESTAL, j ? 8'h20 : 8'h18);
      wr(ADDR_LOOP_EN, 8'h40);
      for (n = 0; data_word !== w0 && n < 1000; n++)
        tick(1);
      check(n >= (steps-1)*per && n <= (steps+1)*per + 30, 1'b1);
      tick(40);
      check(data_word, w0);
      wr(ADDR_LOOP_EN, 8'h00);
      tick(26);
      check(data_word, 11'h3f8);
    end
    $display("test offset loop done");
    for (int lv = 0; lv < 2; lv++) begin
      lvds_mode = lv[0];
      indep_ctrl = lv[0];
      for (int c = 0; c < 8; c++) begin
        set_pat(c[2:0]);
        tick(3);
        w0 = (c == 0) ? 11'h3f8 : (c == 2) ? FULL_SCALE : (c == 5)
           ? {custom_high_reg[5:0], custom_low_reg[7:3]} : 11'h000;
        if (c == 3) begin
          w0 = data_word;
          tick(1);
          check(data_word, 11'(~w0));
          check(w0 == TOGGLE_A || w0 == TOGGLE_B, 1'b1);
        end else if (c == 4) begin
          ramp_step();
        end else begin
          check(data_word, w0);
        end
        check(dummy_bit, lv == 1 && c == 2);
      end
    end
    set_pat(3'h0);
    indep_ctrl = 1'b0;
    cha_pattern_code = 3'h0;
    tick(3);
    check(dummy_bit, 1'b0);
    check(data_word, 11'h3f8);
    $display("test patterns done");
    summarize();
  end
endmodule

`default_nettype wire
